// ---- design/iwal_pkg.sv ----
// Shared constants for the input window alarm device and host ends
package iwal_pkg;
    localparam int NUM_ALARM = 4;
    localparam int NUM_GPIO = 6;
    localparam int CH_W = 4;
    localparam int RES_W = 12;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int HADDR_W = 3;

    // Device register indices
    localparam logic [ADDR_W-1:0] REG_ALARM = 6'h00;
    localparam logic [ADDR_W-1:0] REG_ADC_CTRL = 6'h08;
    localparam logic [ADDR_W-1:0] REG_GPIO = 6'h09;
    localparam logic [ADDR_W-1:0] REG_PWRDN = 6'h0A;
    localparam logic [ADDR_W-1:0] REG_RESET = 6'h0B;
    localparam logic [ADDR_W-1:0] REG_DAC_DATA = 6'h0C;
    // Thresholds: upper at THR_BASE+2n, lower at THR_BASE+2n+1
    localparam logic [ADDR_W-1:0] REG_THR_BASE = 6'h10;
    localparam logic [2:0] THR_BASE_HI = 3'h2;

    // Field positions
    localparam int ADC_AUTO_BIT = 15;
    localparam int ADC_FIRST_LSB = 8;
    localparam int ADC_LAST_LSB = 4;
    localparam int GPIO_FSEL_LSB = 8;

    // Reset values
    localparam logic [RES_W-1:0] THR_HI_RST = 12'hFFF;
    localparam logic [RES_W-1:0] THR_LO_RST = 12'h000;
    localparam logic [RES_W-1:0] THR_FULL_SCALE = 12'hFFF;
    localparam logic [RES_W-1:0] THR_ZERO = 12'h000;
    localparam logic [CH_W-1:0] FIRST_RST = 4'h0;
    localparam logic [CH_W-1:0] LAST_RST = 4'h0;
    localparam logic [NUM_ALARM-1:0] FSEL_RST = 4'hF;
    localparam logic [NUM_GPIO-1:0] PSTATE_RST = 6'h3F;
    localparam logic [DATA_W-1:0] PWRDN_RST = 16'h0000;
    // Arbitrary key value that triggers a software reset
    localparam logic [DATA_W-1:0] SOFT_RST_KEY = 16'h5A5A;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int DAV_PULSE_NS = 2000;
    localparam int DAV_PULSE_CYC = (DAV_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int DAV_CNT_W = 6;

    // Host register offsets
    localparam logic [HADDR_W-1:0] H_ADDR = 3'h0;
    localparam logic [HADDR_W-1:0] H_WDATA = 3'h1;
    localparam logic [HADDR_W-1:0] H_CTRL = 3'h2;
    localparam logic [HADDR_W-1:0] H_RDATA = 3'h3;
    localparam logic [HADDR_W-1:0] H_STAT = 3'h4;
    localparam logic [HADDR_W-1:0] H_GPIO = 3'h5;
    localparam int HC_GO_WR = 0;
    localparam int HC_GO_RD = 1;
    localparam int HC_DAC_LOAD = 2;
    localparam int HS_BUSY = 0;
    localparam int HS_GLOBAL_ALARM_OUT_N = 1;
    localparam int HS_DONE = 2;
    localparam int HS_GPIO_LSB = 8;

    typedef enum logic [3:0] {
        IWAL_H_BOOT = 4'b0001,
        IWAL_H_IDLE = 4'b0010,
        IWAL_H_STROBE = 4'b0100,
        IWAL_H_CAPT = 4'b1000
    } iwal_hstate_t;
endpackage

// ---- design/iwal_if.sv ----
// Link between the alarm device and its host: register port and pins
`timescale 1ns/1ps
`default_nettype none
interface iwal_if;
    import iwal_pkg::*;
    logic [ADDR_W-1:0] link_addr;
    logic [DATA_W-1:0] link_wdata;
    logic link_wr;
    logic link_rd;
    logic link_sel_n;
    logic [DATA_W-1:0] link_rdata;
    logic global_alarm_out_n;
    logic conversion_done_out_n;
    logic ext_dac_load_in;
    logic [NUM_GPIO-1:0] gpio_dev_o;
    logic [NUM_GPIO-1:0] gpio_dev_oe_n;
    logic [NUM_GPIO-1:0] gpio_host_o;
    logic [NUM_GPIO-1:0] gpio_host_oe_n;
    logic [NUM_GPIO-1:0] gpio_lvl;

    // Wired-AND with pull-up: a pin is low when either end drives it low
    assign gpio_lvl = (gpio_dev_oe_n | gpio_dev_o)
                      & (gpio_host_oe_n | gpio_host_o);

    modport dev (
        input link_addr, link_wdata, link_wr, link_rd, link_sel_n,
        input ext_dac_load_in, gpio_lvl,
        output link_rdata, global_alarm_out_n, conversion_done_out_n,
        output gpio_dev_o, gpio_dev_oe_n
    );
    modport host (
        output link_addr, link_wdata, link_wr, link_rd, link_sel_n,
        output ext_dac_load_in, gpio_host_o, gpio_host_oe_n,
        input link_rdata, global_alarm_out_n, conversion_done_out_n,
        input gpio_lvl
    );
endinterface
`default_nettype wire

// ---- design/iwal_device.sv ----
// Device end: window comparators, alarm flags, alarm pins and registers
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module iwal_device
    import iwal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    iwal_if.dev lnk,
    input wire logic res_valid,
    input wire logic [CH_W-1:0] res_ch,
    input wire logic [RES_W-1:0] res_data,
    input wire logic group_done,
    output logic cmd_start,
    output logic [CH_W-1:0] cmd_first,
    output logic [CH_W-1:0] cmd_last,
    output logic cmd_auto,
    output logic [DATA_W-1:0] pwrdn
);
    logic srst_r;
    logic clr;
    logic wr;
    logic rd;
    logic cmd_wr;
    logic [RES_W-1:0] thr_hi_r [NUM_ALARM];
    logic [RES_W-1:0] thr_lo_r [NUM_ALARM];
    logic [CH_W-1:0] first_r;
    logic [CH_W-1:0] last_r;
    logic auto_r;
    logic [NUM_ALARM-1:0] fsel_r;
    logic [NUM_GPIO-1:0] pstate_r;
    logic [DATA_W-1:0] pwrdn_r;
    logic [DATA_W-1:0] dac_hold_r;
    logic [NUM_ALARM-1:0] flag_r;
    logic [NUM_ALARM-1:0] pend_r;
    logic [NUM_ALARM-1:0] pend_nxt;
    logic [NUM_ALARM-1:0] inv;
    logic [NUM_ALARM-1:0] dflt;
    logic [CH_W-1:0] pos;
    logic [CH_W-1:0] span;
    logic [CH_W-1:0] span_new;
    logic [NUM_GPIO-1:0] pin_rd;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] rdata_r;
    logic [DAV_CNT_W-1:0] dav_cnt_r;
    logic dav_n_r;
    logic global_alarm_out_n_n_r;
    logic [NUM_GPIO-1:0] gpio_oe_n_r;
    logic [NUM_GPIO-1:0] gpio_o_r;
    logic cmd_start_r;

    // Hardware and software reset have the same reach
    assign clr = !rst_n || srst_r;
    assign wr = lnk.link_wr && !lnk.link_sel_n;
    assign rd = lnk.link_rd && !lnk.link_sel_n;
    assign cmd_wr = wr && (lnk.link_addr == REG_ADC_CTRL);
    assign span_new = CH_W'(lnk.link_wdata[ADC_FIRST_LSB-1 -: CH_W]
                      - lnk.link_wdata[ADC_FIRST_LSB +: CH_W]);

    ////////////////////////////////////////////////////////////////////
    // Soft reset and configuration registers

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            srst_r <= 1'b0;
        end else if (ce) begin
            srst_r <= wr && (lnk.link_addr == REG_RESET)
                      && (lnk.link_wdata == SOFT_RST_KEY);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            for (int n = 0; n < NUM_ALARM; n++) begin
                thr_hi_r[n] <= THR_HI_RST;
                thr_lo_r[n] <= THR_LO_RST;
            end
            first_r <= FIRST_RST;
            last_r <= LAST_RST;
            auto_r <= 1'b0;
            fsel_r <= FSEL_RST;
            pstate_r <= PSTATE_RST;
            pwrdn_r <= PWRDN_RST;
        end else if (ce && wr) begin
            if (lnk.link_addr[ADDR_W-1:3] == THR_BASE_HI) begin
                if (lnk.link_addr[0])
                    thr_lo_r[lnk.link_addr[2:1]] <= lnk.link_wdata[RES_W-1:0];
                else
                    thr_hi_r[lnk.link_addr[2:1]] <= lnk.link_wdata[RES_W-1:0];
            end
            if (cmd_wr) begin
                first_r <= lnk.link_wdata[ADC_FIRST_LSB +: CH_W];
                last_r <= lnk.link_wdata[ADC_LAST_LSB +: CH_W];
                auto_r <= lnk.link_wdata[ADC_AUTO_BIT];
            end
            if (lnk.link_addr == REG_GPIO) begin
                fsel_r <= lnk.link_wdata[GPIO_FSEL_LSB +: NUM_ALARM];
                pstate_r <= lnk.link_wdata[NUM_GPIO-1:0];
            end
            if (lnk.link_addr == REG_PWRDN)
                pwrdn_r <= lnk.link_wdata;
        end
    end

    // DAC input data survives every reset; it is data, not control
    always_ff @(posedge clk_sys) begin
        if (ce && wr && (lnk.link_addr == REG_DAC_DATA))
            dac_hold_r <= lnk.link_wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // Window comparison

    assign pos = CH_W'(res_ch - first_r);
    assign span = CH_W'(last_r - first_r);

    always_comb begin
        pend_nxt = pend_r;
        for (int n = 0; n < NUM_ALARM; n++) begin
            inv[n] = thr_hi_r[n] < thr_lo_r[n];
            dflt[n] = (thr_hi_r[n] == THR_HI_RST)
                      && (thr_lo_r[n] == THR_LO_RST);
            // Equality with a bound stays inside the window
            if (res_valid && (pos == CH_W'(n)) && (pos <= span))
                pend_nxt[n] = (res_data > thr_hi_r[n])
                              || (res_data < thr_lo_r[n]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr || (ce && cmd_wr)) begin
            pend_r <= '0;
        end else if (ce) begin
            pend_r <= pend_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm flags: they move at group completion, a new command, or at once on inverted or default thresholds

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            flag_r <= '0;
        end else if (ce) begin
            for (int n = 0; n < NUM_ALARM; n++) begin
                if (inv[n])
                    flag_r[n] <= 1'b1;
                else if (dflt[n])
                    flag_r[n] <= 1'b0;
                else if (group_done)
                    flag_r[n] <= pend_nxt[n];
                else if (cmd_wr && (CH_W'(n) > span_new))
                    flag_r[n] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion done pin: timed pulse in auto mode, level in direct

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            dav_n_r <= 1'b1;
            dav_cnt_r <= '0;
        end else if (ce) begin
            if (group_done) begin
                dav_n_r <= 1'b0;
                dav_cnt_r <= auto_r ? DAV_CNT_W'(DAV_PULSE_CYC) : '0;
            end else if (cmd_wr) begin
                dav_n_r <= 1'b1;
                dav_cnt_r <= '0;
            end else if (dav_cnt_r != '0) begin
                dav_cnt_r <= DAV_CNT_W'(dav_cnt_r - 1'b1);
                if (dav_cnt_r == DAV_CNT_W'(1))
                    dav_n_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pins and command outputs

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            global_alarm_out_n_n_r <= 1'b1;
            gpio_oe_n_r <= '1;
            gpio_o_r <= '0;
        end else if (ce) begin
            global_alarm_out_n_n_r <= ~|flag_r;
            for (int n = 0; n < NUM_ALARM; n++) begin
                if (!fsel_r[n])
                    gpio_oe_n_r[n] <= ~flag_r[n];
                else
                    gpio_oe_n_r[n] <= pstate_r[n];
            end
            // The two top pins have no alarm path at all
            gpio_oe_n_r[NUM_GPIO-1:NUM_ALARM]
                <= pstate_r[NUM_GPIO-1:NUM_ALARM];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            cmd_start_r <= 1'b0;
        end else if (ce) begin
            cmd_start_r <= cmd_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read back

    always_comb begin
        pin_rd = lnk.gpio_lvl;
        for (int n = 0; n < NUM_ALARM; n++) begin
            if (!fsel_r[n])
                pin_rd[n] = ~flag_r[n];
        end
        rd_val = ZERO_WORD;
        if (lnk.link_addr[ADDR_W-1:3] == THR_BASE_HI)
            rd_val[RES_W-1:0] = lnk.link_addr[0] ? thr_lo_r[lnk.link_addr[2:1]]
                                                 : thr_hi_r[lnk.link_addr[2:1]];
        else if (lnk.link_addr == REG_ALARM)
            rd_val[NUM_ALARM-1:0] = flag_r;
        else if (lnk.link_addr == REG_ADC_CTRL) begin
            rd_val[ADC_AUTO_BIT] = auto_r;
            rd_val[ADC_FIRST_LSB +: CH_W] = first_r;
            rd_val[ADC_LAST_LSB +: CH_W] = last_r;
        end else if (lnk.link_addr == REG_GPIO) begin
            rd_val[GPIO_FSEL_LSB +: NUM_ALARM] = fsel_r;
            rd_val[NUM_GPIO-1:0] = pin_rd;
        end else if (lnk.link_addr == REG_PWRDN)
            rd_val = pwrdn_r;
        else if (lnk.link_addr == REG_DAC_DATA)
            rd_val = dac_hold_r;
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            rdata_r <= ZERO_WORD;
        end else if (ce && rd) begin
            rdata_r <= rd_val;
        end
    end

    assign lnk.link_rdata = rdata_r;
    assign lnk.global_alarm_out_n = global_alarm_out_n_n_r;
    assign lnk.conversion_done_out_n = dav_n_r;
    assign lnk.gpio_dev_oe_n = gpio_oe_n_r;
    assign lnk.gpio_dev_o = gpio_o_r;
    assign cmd_start = cmd_start_r;
    assign cmd_first = first_r;
    assign cmd_last = last_r;
    assign cmd_auto = auto_r;
    assign pwrdn = pwrdn_r;
endmodule // iwal_device
`default_nettype wire

// ---- design/iwal_host.sv ----
// Host end: link access sequencer with a small software register port
`timescale 1ns/1ps
`default_nettype none
module iwal_host
    import iwal_pkg::*;
#(
    parameter logic [DATA_W-1:0] PWRDN_BOOT = 16'hFFFF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    iwal_if.host lnk,
    input wire logic [HADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata
);
    iwal_hstate_t st_r;
    logic [ADDR_W-1:0] laddr_r;
    logic [DATA_W-1:0] lwdata_r;
    logic [DATA_W-1:0] lrdata_r;
    logic [ADDR_W-1:0] link_addr_r;
    logic [DATA_W-1:0] link_wdata_r;
    logic link_wr_r;
    logic link_rd_r;
    logic link_sel_n_r;
    logic dac_load_r;
    logic [NUM_GPIO-1:0] gpio_oe_n_r;
    logic [DATA_W-1:0] rdata_r;
    logic go_wr;
    logic go_rd;

    // Software may set one-sided windows with THR_ZERO or THR_FULL_SCALE
    assign go_wr = wr && (addr == H_CTRL) && wdata[HC_GO_WR];
    assign go_rd = wr && (addr == H_CTRL) && wdata[HC_GO_RD]
                   && !wdata[HC_GO_WR];

    ////////////////////////////////////////////////////////////////////
    // Link sequencer; a go while busy is dropped

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= IWAL_H_BOOT;
            link_sel_n_r <= 1'b1;
            link_wr_r <= 1'b0;
            link_rd_r <= 1'b0;
            link_addr_r <= REG_ALARM;
            link_wdata_r <= ZERO_WORD;
            lrdata_r <= ZERO_WORD;
        end else if (ce) begin
            unique case (st_r)
                IWAL_H_BOOT: begin
                    // Device wakes fully powered down; enable it first
                    link_addr_r <= REG_PWRDN;
                    link_wdata_r <= PWRDN_BOOT;
                    link_wr_r <= 1'b1;
                    link_sel_n_r <= 1'b0;
                    st_r <= IWAL_H_STROBE;
                end
                IWAL_H_IDLE: begin
                    if (go_wr || go_rd) begin
                        link_addr_r <= laddr_r;
                        link_wdata_r <= lwdata_r;
                        link_wr_r <= go_wr;
                        link_rd_r <= go_rd;
                        link_sel_n_r <= 1'b0;
                        st_r <= IWAL_H_STROBE;
                    end
                end
                IWAL_H_STROBE: begin
                    link_wr_r <= 1'b0;
                    link_rd_r <= 1'b0;
                    link_sel_n_r <= 1'b1;
                    st_r <= IWAL_H_CAPT;
                end
                IWAL_H_CAPT: begin
                    lrdata_r <= lnk.link_rdata;
                    st_r <= IWAL_H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            laddr_r <= REG_ALARM;
            lwdata_r <= ZERO_WORD;
            dac_load_r <= 1'b0;
            gpio_oe_n_r <= '1;
        end else if (ce && wr) begin
            if (addr == H_ADDR)
                laddr_r <= wdata[ADDR_W-1:0];
            if (addr == H_WDATA)
                lwdata_r <= wdata;
            if (addr == H_CTRL)
                dac_load_r <= wdata[HC_DAC_LOAD];
            if (addr == H_GPIO)
                gpio_oe_n_r <= wdata[NUM_GPIO-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_r <= ZERO_WORD;
        end else if (ce && rd) begin
            rdata_r <= ZERO_WORD;
            unique case (addr)
                H_ADDR: rdata_r[ADDR_W-1:0] <= laddr_r;
                H_WDATA: rdata_r <= lwdata_r;
                H_CTRL: rdata_r[HC_DAC_LOAD] <= dac_load_r;
                H_RDATA: rdata_r <= lrdata_r;
                H_STAT: begin
                    rdata_r[HS_BUSY] <= (st_r != IWAL_H_IDLE);
                    rdata_r[HS_GLOBAL_ALARM_OUT_N] <= lnk.global_alarm_out_n;
                    rdata_r[HS_DONE] <= lnk.conversion_done_out_n;
                    rdata_r[HS_GPIO_LSB +: NUM_GPIO] <= lnk.gpio_lvl;
                end
                H_GPIO: rdata_r[NUM_GPIO-1:0] <= gpio_oe_n_r;
                default: rdata_r <= ZERO_WORD;
            endcase
        end
    end

    assign rdata = rdata_r;
    assign lnk.link_addr = link_addr_r;
    assign lnk.link_wdata = link_wdata_r;
    assign lnk.link_wr = link_wr_r;
    assign lnk.link_rd = link_rd_r;
    assign lnk.link_sel_n = link_sel_n_r;
    assign lnk.ext_dac_load_in = dac_load_r;
    assign lnk.gpio_host_oe_n = gpio_oe_n_r;
    assign lnk.gpio_host_o = '0;
endmodule // iwal_host
`default_nettype wire

// ---- test/iwal_alarm_checker.sv ----
// Concurrent checks on the link between the alarm device and its host
`timescale 1ns/1ps
`default_nettype none
module iwal_alarm_checker
    import iwal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] link_addr,
    input wire logic link_wr,
    input wire logic link_rd,
    input wire logic link_sel_n,
    input wire logic [DATA_W-1:0] link_rdata,
    input wire logic global_alarm_out_n,
    input wire logic conversion_done_out_n,
    input wire logic ext_dac_load_in,
    input wire logic [NUM_GPIO-1:0] gpio_dev_o,
    input wire logic [NUM_GPIO-1:0] gpio_dev_oe_n,
    input wire logic [NUM_GPIO-1:0] gpio_lvl
);
    logic io_wr;

    // A register write that may legally move the plain io pins
    assign io_wr = link_wr && !link_sel_n
                   && (link_addr == REG_GPIO || link_addr == REG_RESET);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_reset_pins_idle: assert property (
        $rose(rst_n) |-> global_alarm_out_n && conversion_done_out_n
        && gpio_dev_oe_n == 6'h3F)
        else $error("alarm outputs active after reset");
    a_boot_link_quiet: assert property (
        $rose(rst_n) |-> link_sel_n && !ext_dac_load_in)
        else $error("select or load active after reset");
    // Pins four and five move only two edges after a pin or reset write
    a_plain_io_pins: assert property (
        $changed(gpio_dev_oe_n[5:4]) |-> $past(io_wr, 2))
        else $error("plain io pin moved without a pin write");
    a_pin_never_high: assert property (
        gpio_dev_o == 6'h00)
        else $error("device drives a pin high");
    // Holds only while pins 0..3 are never set as driven outputs
    a_pin_needs_global: assert property (
        !(&gpio_dev_oe_n[3:0]) |-> !global_alarm_out_n)
        else $error("alarm pin low with global alarm high");
    a_done_low_hold: assert property (
        $fell(conversion_done_out_n) |-> !conversion_done_out_n [*8])
        else $error("done output low too briefly");
    a_flag_upper_zero: assert property (
        link_rd && !link_sel_n && link_addr == REG_ALARM
        |=> link_rdata[DATA_W-1:NUM_ALARM] == 12'h000)
        else $error("flag register shows more than four flags");
    a_global_vs_flags: assert property (
        link_rd && !link_sel_n && link_addr == REG_ALARM
        |=> (|link_rdata[3:0]) == !global_alarm_out_n)
        else $error("global alarm disagrees with flags");
    a_pin_state_level: assert property (
        link_rd && !link_sel_n && link_addr == REG_GPIO
        |=> link_rdata[5:0] == gpio_lvl)
        else $error("pin state bits disagree with pins");
endmodule // iwal_alarm_checker
`default_nettype wire

// ---- test/test_input_window_alarm_logic.sv ----
// Self-checking bench for the alarm device and host pair
`timescale 1ns/1ps
`default_nettype none
module test_input_window_alarm_logic
    import iwal_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [HADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic res_valid = 1'b0;
    logic [CH_W-1:0] res_ch = 4'h0;
    logic [RES_W-1:0] res_data = 12'h000;
    logic group_done = 1'b0;
    logic [DATA_W-1:0] pwrdn;
    logic [CH_W-1:0] cmd_first;
    logic [CH_W-1:0] cmd_last;
    logic cmd_auto;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    always #25 clk_sys = ~clk_sys;

    iwal_if lnk_if();
    iwal_device u_iwal_device (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .lnk(lnk_if), .res_valid(res_valid), .res_ch(res_ch),
        .res_data(res_data), .group_done(group_done), .cmd_start(),
        .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_auto(cmd_auto),
        .pwrdn(pwrdn));
    iwal_host #(.PWRDN_BOOT(16'h1234)) u_iwal_host (.clk_sys(clk_sys),
        .rst_n(rst_n), .ce(1'b1), .lnk(lnk_if), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    iwal_alarm_checker u_iwal_alarm_checker (.clk_sys(clk_sys),
        .rst_n(rst_n), .link_addr(lnk_if.link_addr),
        .link_wr(lnk_if.link_wr), .link_rd(lnk_if.link_rd),
        .link_sel_n(lnk_if.link_sel_n), .link_rdata(lnk_if.link_rdata),
        .global_alarm_out_n(lnk_if.global_alarm_out_n),
        .conversion_done_out_n(lnk_if.conversion_done_out_n),
        .ext_dac_load_in(lnk_if.ext_dac_load_in),
        .gpio_dev_o(lnk_if.gpio_dev_o), .gpio_dev_oe_n(lnk_if.gpio_dev_oe_n),
        .gpio_lvl(lnk_if.gpio_lvl));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Mismatches %0d in %0d compares", n_mismatch,
            samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe is dropped with a spare cycle so back-to-back calls never clash
    task automatic sw_wr(input logic [HADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic sw_rd(input logic [HADDR_W-1:0] a,
        output logic [DATA_W-1:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(posedge clk_sys);
        d = rdata;
    endtask

    task automatic idle_wait;
        logic [DATA_W-1:0] s;
        s = 16'hFFFF;
        for (int i = 0; i < 8 && s[HS_BUSY] !== 1'b0; i++) sw_rd(H_STAT, s);
        chk({15'h0000, s[HS_BUSY]}, 16'h0000);
    endtask

    task automatic lw(input logic [ADDR_W-1:0] idx,
        input logic [DATA_W-1:0] d);
        sw_wr(H_ADDR, {10'h000, idx});
        sw_wr(H_WDATA, d);
        sw_wr(H_CTRL, 16'h0001);
        idle_wait;
    endtask

    task automatic lchk(input logic [ADDR_W-1:0] idx,
        input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        sw_wr(H_ADDR, {10'h000, idx});
        sw_wr(H_CTRL, 16'h0002);
        idle_wait;
        sw_rd(H_RDATA, d);
        chk(d, e);
    endtask

    task automatic res(input logic [CH_W-1:0] c, input logic [RES_W-1:0] v);
        res_valid <= 1'b1;
        res_ch <= c;
        res_data <= v;
        @(posedge clk_sys);
        res_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Pulse, then spare edges so pins, which trail the flags, settle
    task automatic gdone;
        group_done <= 1'b1;
        @(posedge clk_sys);
        group_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(pwrdn, 16'h1234);
        lchk(REG_ALARM, 16'h0000);
        lchk(REG_GPIO, 16'h0F3F);
        lchk(6'h3F, 16'h0000);
        lw(REG_GPIO, 16'h003F);
        lw(6'h10, 16'h0800);
        lw(6'h12, 16'h0800);
        lw(6'h13, 16'h0100);
        lw(6'h14, 16'h0800);
        lw(6'h15, 16'h0100);
        lw(REG_ADC_CTRL, 16'h0490);
        res(4'h4, 12'h123);
        res(4'h5, 12'h801);
        res(4'h6, 12'h800);
        res(4'h7, 12'hFFF);
        res(4'h8, 12'hFFF);
        lchk(REG_ALARM, 16'h0000);
        gdone;
        lchk(REG_ALARM, 16'h0002);
        chk({15'h0000, lnk_if.global_alarm_out_n}, 16'h0000);
        chk({10'h000, lnk_if.gpio_lvl}, 16'h003D);
        chk({15'h0000, lnk_if.conversion_done_out_n}, 16'h0000);
        lchk(REG_GPIO, 16'h003D);
        lw(6'h16, 16'h0100);
        lw(6'h17, 16'h0200);
        lchk(REG_ALARM, 16'h000A);
        res(4'h5, 12'h100);
        res(4'h6, 12'h0FF);
        lchk(REG_ALARM, 16'h000A);
        gdone;
        lchk(REG_ALARM, 16'h000C);
        lw(6'h16, 16'h0FFF);
        lw(6'h17, 16'h0000);
        lchk(REG_ALARM, 16'h0004);
        lw(REG_ADC_CTRL, 16'h0450);
        lchk(REG_ALARM, 16'h0000);
        chk({15'h0000, lnk_if.global_alarm_out_n}, 16'h0001);
        sw_wr(H_GPIO, 16'h002F);
        lchk(REG_GPIO, 16'h002F);
        sw_wr(H_GPIO, 16'h003F);
        lw(REG_GPIO, 16'h001F);
        chk({10'h000, lnk_if.gpio_lvl}, 16'h001F);
        lw(REG_GPIO, 16'h003F);
        lw(REG_ADC_CTRL, 16'h8450);
        chk({7'h00, cmd_auto, cmd_first, cmd_last}, 16'h0145);
        res(4'h5, 12'hFFF);
        group_done <= 1'b1;
        @(posedge clk_sys);
        group_done <= 1'b0;
        // Look one edge on, while the first low cycle still stands
        @(posedge clk_sys);
        n = 0;
        while (lnk_if.conversion_done_out_n === 1'b0 && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
        chk(n[15:0], DAV_PULSE_CYC[15:0]);
        lchk(REG_ALARM, 16'h0002);
        res(4'h5, 12'h100);
        gdone;
        lchk(REG_ALARM, 16'h0000);
        res(4'h5, 12'hFFF);
        gdone;
        lw(REG_DAC_DATA, 16'hC3A5);
        lw(REG_RESET, SOFT_RST_KEY);
        chk({15'h0000, lnk_if.global_alarm_out_n}, 16'h0001);
        chk(pwrdn, PWRDN_RST);
        lchk(REG_ALARM, 16'h0000);
        lchk(REG_GPIO, 16'h0F3F);
        lchk(REG_DAC_DATA, 16'hC3A5);
        tally_and_finish;
    end
endmodule // test_input_window_alarm_logic
`default_nettype wire
